// ---- blk_cfg_map.svh ----
`ifndef BLK_CFG_MAP_SVH
`define BLK_CFG_MAP_SVH

// Configuration space byte offsets, packed in field order.
`define OFS_SIZE_LO 8'h00
`define OFS_SIZE_HI 8'h04
`define OFS_SEG_SIZE 8'h08
`define OFS_SEG_COUNT 8'h0c
`define OFS_GEOMETRY 8'h10
`define OFS_BLOCK_BYTES 8'h14
`define OFS_TOPOLOGY 8'h18
`define OFS_OPT_XFER 8'h1c
`define OFS_CACHE_MODE 8'h20
`define OFS_DISC_SECT 8'h24
`define OFS_DISC_SEG 8'h28
`define OFS_DISC_ALIGN 8'h2c
`define OFS_ZF_SECT 8'h30
`define OFS_ZF_SEG 8'h34
`define OFS_ZF_DEALLOC 8'h38
// Feature, negotiation, control and request registers.
`define OFS_DEV_FEAT 8'h40
`define OFS_DRV_FEAT 8'h44
`define OFS_DEV_STATUS 8'h48
`define OFS_CTRL 8'h4c
`define OFS_REQ 8'h50
`define OFS_REQ_STATUS 8'h54

// Feature bit positions.
`define FB_BARRIER 0
`define FB_SEG_SIZE 1
`define FB_SEG_COUNT 2
`define FB_GEOMETRY 4
`define FB_READ_ONLY 5
`define FB_BLOCK_BYTES 6
`define FB_PKT_CMD 7
`define FB_FLUSH 9
`define FB_TOPOLOGY 10
`define FB_CACHE_SWITCH 11
`define FB_DISCARD 13
`define FB_ZERO_FILL 14

// Device status bits.
`define ST_DRIVER 1
`define ST_DRIVER_READY 2
`define ST_FEAT_ACCEPTED 3

// Request type codes.
`define RQT_READ 8'h00
`define RQT_WRITE 8'h01
`define RQT_FLUSH 8'h04
`define RQT_DISCARD 8'h0b
`define RQT_ZERO_FILL 8'h0d

// Configuration values and reset values.
`define VAL_SIZE 64'h0000_0000_0010_0000
`define VAL_SEG_SIZE 32'h0001_0000
`define VAL_SEG_COUNT 32'h0000_0080
`define VAL_CYLINDERS 16'h0400
`define VAL_HEADS 8'h10
`define VAL_SECTORS 8'h3f
`define VAL_BLOCK_BYTES 32'h0000_0200
`define VAL_PHYS_LOG2 8'h03
`define VAL_ALIGN_BLOCK 8'h00
`define VAL_MIN_XFER 16'h0001
`define VAL_OPT_XFER 32'h0000_0100
`define VAL_DISC_SECT 32'h0000_ffff
`define VAL_DISC_SEG 32'h0000_0001
`define VAL_DISC_ALIGN 32'h0000_0008
`define VAL_ZF_SECT 32'h0000_ffff
`define VAL_ZF_SEG 32'h0000_0001
`define VAL_ZF_DEALLOC 8'h01
`define VAL_PKT_OFFER 1'b0
`define RST_CACHE_MODE 1'b1
`define RST_CTRL 6'h08

`endif

// ---- blk_cfg_pkg.sv ----
package blk_cfg_pkg;

	// Completion codes of a request, in code order 0, 1, 2.
	typedef enum logic [1:0] {
		RS_OK,
		RS_IOERR,
		RS_UNSUPP
	} req_status_t;

	// Control register: legacy, guest big-endian, read-only, flush, switch, spare.
	typedef struct packed {
		logic spare;
		logic switch_offer;
		logic flush_offer;
		logic read_only;
		logic guest_be;
		logic legacy;
	} ctrl_t;

	// Whole state of the block.
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		logic cache_mode;
		logic [31:0] drv_feat;
		logic [7:0] dev_status;
		ctrl_t ctrl;
		req_status_t req_status;
		logic req_done;
		logic commit;
	} state_t;

endpackage

// ---- blk_cfg.sv ----
// Contract
// RQ1: Requests written to the request register are serviced and completed one at a time.
// RQ2: Feature bits 1, 2 and 4 advertise segment size, segment count, geometry.
// RQ3: With read-only advertised at bit 5, every write request fails.
// RQ4: Flush advertised at bit 9, cache mode switching at bit 11.
// RQ5: Bit 13 announces discard with valid discard limit fields.
// RQ6: Bit 14 announces zero fill with valid zero fill limit fields.
// RQ7: Bit 10 marks topology valid, bit 6 marks block size valid.
// RQ8: Legacy interface uses bit 0 for barriers, bit 7 for packet commands.
// RQ9: Medium size always readable, counted in 512-byte sectors.
// RQ10: Discard and zero fill limits are given in 512-byte units.
// RQ11: Preferred block size never changes the 512-byte protocol sector unit.
// RQ12: With switching negotiated the cache byte is writable; 0 writethrough, 1 writeback.
// RQ13: Reset mode is either; after negotiation the byte shows the mode in force.
// RQ14: Driver reads the cache byte only after setting features accepted.
// RQ15: Flush always advertised, and surely whenever switching is advertised; the code drops flush while ctrl flush_offer and switch_offer are both clear.
// RQ16: Switching negotiated without flush forces the cache byte to writethrough.
// RQ17: Both three-byte padding areas read as zero.
// RQ18: A driver unable to flush should not accept flush.
// RQ19: Driver assumes writethrough without both, writeback with flush only.
// RQ20: Legacy status writes keep the mode, except driver ready without switching accepted; the code also resets the mode to 1 on a status write of zero.
// RQ21: Legacy driver feature writes never alter the cache mode.
// RQ22: Legacy driver may access the cache byte before driver status bits.
// RQ23: Legacy multi-byte fields use guest byte order, otherwise little-endian.
// RQ24: Fields packed contiguously in order, gaps only at the two padding areas.
`timescale 1ns/10ps
`default_nettype none
`include "blk_cfg_map.svh"

module blk_cfg (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst_b,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Backend side.
	output logic cache_writeback,
	output logic write_commit
);

	blk_cfg_pkg::state_t s_r;
	blk_cfg_pkg::state_t s_nxt;
	logic [31:0] dev_feat;
	logic swap;
	logic req_acc;
	logic wr_acc;
	// Wide constants are named so that single words and bytes can be selected from them.
	localparam logic [63:0] size_val = `VAL_SIZE;
	localparam logic [31:0] seg_size_val = `VAL_SEG_SIZE;

	// Byte swap of a 16-bit field.
	function automatic logic [15:0] sw16(input logic [15:0] x, input logic en);
		sw16 = en ? {x[7:0], x[15:8]} : x;
	endfunction

	// Byte swap of a 32-bit field.
	function automatic logic [31:0] sw32(input logic [31:0] x, input logic en);
		sw32 = en ? {x[7:0], x[15:8], x[23:16], x[31:24]} : x;
	endfunction

	// Byte-lane merge of a write into a stored word.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		integer i;
		merge = old;
		for (i = 0; i < 4; i++) begin
			if (sel[i]) begin
				merge[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
	endfunction

	// Cache mode that the negotiated feature set puts in force.
	function automatic logic mode_in_force(input logic [31:0] f, input logic cur);
		if (f[`FB_CACHE_SWITCH] && !f[`FB_FLUSH]) begin
			mode_in_force = 1'b0; // RQ16
		end else if (f[`FB_CACHE_SWITCH]) begin
			mode_in_force = cur;
		end else begin
			mode_in_force = f[`FB_FLUSH]; // RQ13
		end
	endfunction

	// Advertised features follow the control register; flush is forced on with switching.
	always_comb begin
		dev_feat = 32'h0;
		dev_feat[`FB_SEG_SIZE] = 1'b1; // RQ2
		dev_feat[`FB_SEG_COUNT] = 1'b1; // RQ2
		dev_feat[`FB_GEOMETRY] = 1'b1; // RQ2
		dev_feat[`FB_READ_ONLY] = s_r.ctrl.read_only; // RQ3
		dev_feat[`FB_BLOCK_BYTES] = 1'b1; // RQ7
		dev_feat[`FB_TOPOLOGY] = 1'b1; // RQ7
		dev_feat[`FB_FLUSH] = s_r.ctrl.flush_offer | s_r.ctrl.switch_offer; // RQ4 RQ15
		dev_feat[`FB_CACHE_SWITCH] = s_r.ctrl.switch_offer; // RQ4
		dev_feat[`FB_DISCARD] = 1'b1; // RQ5
		dev_feat[`FB_ZERO_FILL] = 1'b1; // RQ6
		// Single-slot servicing already orders every request, so barriers cost nothing.
		dev_feat[`FB_BARRIER] = s_r.ctrl.legacy; // RQ8
		dev_feat[`FB_PKT_CMD] = s_r.ctrl.legacy & `VAL_PKT_OFFER; // RQ8
		swap = s_r.ctrl.legacy & s_r.ctrl.guest_be; // RQ23
		req_acc = wb_cyc_i & wb_stb_i & ~s_r.ack;
		wr_acc = req_acc & wb_we_i;
	end

	// Next state: bus answer, register writes, negotiation and request servicing.
	always_comb begin
		logic [7:0] st_new;
		logic [7:0] rq;
		st_new = 8'h0;
		rq = 8'h0;
		s_nxt = s_r;
		s_nxt.ack = req_acc;
		s_nxt.dat = 32'h0;
		s_nxt.commit = 1'b0;
		if (req_acc && !wb_we_i) begin
			// Unmapped addresses answer with zero; pad bytes stay zero too.
			case (wb_adr_i)
				`OFS_SIZE_LO: s_nxt.dat = swap ? sw32(size_val[63:32], 1'b1) : size_val[31:0]; // RQ9
				`OFS_SIZE_HI: s_nxt.dat = swap ? sw32(size_val[31:0], 1'b1) : size_val[63:32]; // RQ9
				`OFS_SEG_SIZE: s_nxt.dat = sw32(`VAL_SEG_SIZE, swap);
				`OFS_SEG_COUNT: s_nxt.dat = sw32(`VAL_SEG_COUNT, swap);
				`OFS_GEOMETRY: s_nxt.dat = {`VAL_SECTORS, `VAL_HEADS, sw16(`VAL_CYLINDERS, swap)};
				// The block size is advisory only; sector unit stays 512 bytes.
				`OFS_BLOCK_BYTES: s_nxt.dat = sw32(`VAL_BLOCK_BYTES, swap); // RQ11
				`OFS_TOPOLOGY: s_nxt.dat = {sw16(`VAL_MIN_XFER, swap), `VAL_ALIGN_BLOCK, `VAL_PHYS_LOG2};
				`OFS_OPT_XFER: s_nxt.dat = sw32(`VAL_OPT_XFER, swap);
				`OFS_CACHE_MODE: s_nxt.dat = {24'h0, 7'h0, s_r.cache_mode}; // RQ17 RQ24
				`OFS_DISC_SECT: s_nxt.dat = sw32(`VAL_DISC_SECT, swap); // RQ10
				`OFS_DISC_SEG: s_nxt.dat = sw32(`VAL_DISC_SEG, swap);
				`OFS_DISC_ALIGN: s_nxt.dat = sw32(`VAL_DISC_ALIGN, swap); // RQ10
				`OFS_ZF_SECT: s_nxt.dat = sw32(`VAL_ZF_SECT, swap); // RQ10
				`OFS_ZF_SEG: s_nxt.dat = sw32(`VAL_ZF_SEG, swap);
				`OFS_ZF_DEALLOC: s_nxt.dat = {24'h0, `VAL_ZF_DEALLOC}; // RQ17
				`OFS_DEV_FEAT: s_nxt.dat = dev_feat;
				`OFS_DRV_FEAT: s_nxt.dat = s_r.drv_feat;
				`OFS_DEV_STATUS: s_nxt.dat = {24'h0, s_r.dev_status};
				`OFS_CTRL: s_nxt.dat = {26'h0, s_r.ctrl};
				`OFS_REQ_STATUS: s_nxt.dat = {23'h0, s_r.req_done, 6'h0, s_r.req_status};
				default: s_nxt.dat = 32'h0;
			endcase
		end
		if (wr_acc) begin
			case (wb_adr_i)
				`OFS_CACHE_MODE: begin
					// Legacy drivers may set the mode before negotiation completes.
					if (wb_sel_i[0] && (s_r.ctrl.legacy || s_r.drv_feat[`FB_CACHE_SWITCH])) begin
						s_nxt.cache_mode = wb_dat_i[0]; // RQ12 RQ22
					end
				end
				`OFS_DRV_FEAT: begin
					// Only offered features can be accepted; the mode is left alone.
					s_nxt.drv_feat = merge(s_r.drv_feat, wb_dat_i, wb_sel_i) & dev_feat; // RQ21
				end
				`OFS_DEV_STATUS: begin
					if (wb_sel_i[0]) begin
						st_new = wb_dat_i[7:0];
						s_nxt.dev_status = st_new;
						if (st_new == 8'h0) begin
							// Writing zero resets the negotiation.
							s_nxt.drv_feat = 32'h0;
							s_nxt.cache_mode = `RST_CACHE_MODE; // RQ13
						end else if (!s_r.ctrl.legacy && st_new[`ST_FEAT_ACCEPTED]
							&& !s_r.dev_status[`ST_FEAT_ACCEPTED]) begin
							s_nxt.cache_mode = mode_in_force(s_r.drv_feat, s_r.cache_mode); // RQ13 RQ16
						end else if (s_r.ctrl.legacy && st_new[`ST_DRIVER_READY]
							&& !s_r.dev_status[`ST_DRIVER_READY]
							&& !s_r.drv_feat[`FB_CACHE_SWITCH]) begin
							s_nxt.cache_mode = mode_in_force(s_r.drv_feat, s_r.cache_mode); // RQ20
						end
					end
				end
				`OFS_CTRL: begin
					if (wb_sel_i[0]) begin
						s_nxt.ctrl = blk_cfg_pkg::ctrl_t'(wb_dat_i[5:0]);
					end
				end
				`OFS_REQ: begin
					// One slot: each request completes in the cycle it is written.
					rq = wb_dat_i[7:0];
					s_nxt.req_done = 1'b1; // RQ1
					case (rq)
						`RQT_READ: s_nxt.req_status = blk_cfg_pkg::RS_OK;
						`RQT_WRITE: begin
							if (dev_feat[`FB_READ_ONLY]) begin
								s_nxt.req_status = blk_cfg_pkg::RS_IOERR; // RQ3
							end else begin
								s_nxt.req_status = blk_cfg_pkg::RS_OK;
								s_nxt.commit = 1'b1;
							end
						end
						`RQT_FLUSH: s_nxt.req_status = dev_feat[`FB_FLUSH] ?
							blk_cfg_pkg::RS_OK : blk_cfg_pkg::RS_UNSUPP;
						`RQT_DISCARD: s_nxt.req_status = dev_feat[`FB_READ_ONLY] ?
							blk_cfg_pkg::RS_IOERR : blk_cfg_pkg::RS_OK;
						`RQT_ZERO_FILL: s_nxt.req_status = dev_feat[`FB_READ_ONLY] ?
							blk_cfg_pkg::RS_IOERR : blk_cfg_pkg::RS_OK;
						default: s_nxt.req_status = blk_cfg_pkg::RS_UNSUPP;
					endcase
				end
				default: begin
				end
			endcase
		end
	end

	// State register.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '0;
			s_r.cache_mode <= `RST_CACHE_MODE;
			s_r.ctrl <= blk_cfg_pkg::ctrl_t'(`RST_CTRL);
			s_r.req_status <= blk_cfg_pkg::RS_OK;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs come straight from the state register.
	assign wb_ack_o = s_r.ack;
	assign wb_dat_o = s_r.dat;
	assign cache_writeback = s_r.cache_mode;
	assign write_commit = s_r.commit;

	property p_ro_write_fails;
		@(posedge ref_clk) disable iff (!rst_b)
		(wr_acc && wb_adr_i == `OFS_REQ && wb_dat_i[7:0] == `RQT_WRITE && s_r.ctrl.read_only)
		|=> (s_r.req_status == blk_cfg_pkg::RS_IOERR && !write_commit && s_r.req_done);
	endproperty
	a_ro_write_fails: assert property (p_ro_write_fails) // RQ3
		else $error("Read-only write did not fail.");

	property p_flush_with_switch;
		@(posedge ref_clk) disable iff (!rst_b)
		dev_feat[`FB_CACHE_SWITCH] |-> dev_feat[`FB_FLUSH];
	endproperty
	a_flush_with_switch: assert property (p_flush_with_switch) // RQ15
		else $error("Switch without flush.");

	property p_fixed_features;
		@(posedge ref_clk) disable iff (!rst_b)
		dev_feat[`FB_SEG_SIZE] && dev_feat[`FB_SEG_COUNT] && dev_feat[`FB_GEOMETRY]
		&& dev_feat[`FB_DISCARD] && dev_feat[`FB_ZERO_FILL] && dev_feat[`FB_TOPOLOGY];
	endproperty
	a_fixed_features: assert property (p_fixed_features) // RQ2
		else $error("Feature bit missing.");

	property p_no_flush_writethrough;
		@(posedge ref_clk) disable iff (!rst_b)
		(wr_acc && wb_adr_i == `OFS_DEV_STATUS && wb_sel_i[0] && !s_r.ctrl.legacy
		&& wb_dat_i[`ST_FEAT_ACCEPTED] && !s_r.dev_status[`ST_FEAT_ACCEPTED]
		&& s_r.drv_feat[`FB_CACHE_SWITCH] && !s_r.drv_feat[`FB_FLUSH]) |=> !cache_writeback;
	endproperty
	a_no_flush_writethrough: assert property (p_no_flush_writethrough) // RQ16
		else $error("Mode not 0.");

	property p_pad_zero;
		@(posedge ref_clk) disable iff (!rst_b)
		(req_acc && !wb_we_i && (wb_adr_i == `OFS_CACHE_MODE || wb_adr_i == `OFS_ZF_DEALLOC))
		|=> wb_ack_o && wb_dat_o[31:8] == 24'h0;
	endproperty
	a_pad_zero: assert property (p_pad_zero) // RQ17
		else $error("Padding read nonzero.");

	property p_legacy_feat_keeps_mode;
		@(posedge ref_clk) disable iff (!rst_b)
		(wr_acc && wb_adr_i == `OFS_DRV_FEAT && s_r.ctrl.legacy) |=> $stable(cache_writeback);
	endproperty
	a_legacy_feat_keeps_mode: assert property (p_legacy_feat_keeps_mode) // RQ21
		else $error("Mode moved.");

	property p_legacy_status_keeps_mode;
		@(posedge ref_clk) disable iff (!rst_b)
		(wr_acc && wb_adr_i == `OFS_DEV_STATUS && s_r.ctrl.legacy && wb_dat_i[7:0] != 8'h0
		&& !(wb_dat_i[`ST_DRIVER_READY] && !s_r.dev_status[`ST_DRIVER_READY]))
		|=> $stable(cache_writeback);
	endproperty
	a_legacy_status_keeps_mode: assert property (p_legacy_status_keeps_mode) // RQ20
		else $error("Mode moved.");

	property p_mode_write;
		@(posedge ref_clk) disable iff (!rst_b)
		(wr_acc && wb_adr_i == `OFS_CACHE_MODE && wb_sel_i[0] && s_r.drv_feat[`FB_CACHE_SWITCH])
		|=> cache_writeback == $past(wb_dat_i[0]);
	endproperty
	a_mode_write: assert property (p_mode_write) // RQ12
		else $error("Mode write lost.");

	property p_size_read;
		@(posedge ref_clk) disable iff (!rst_b)
		(req_acc && !wb_we_i && wb_adr_i == `OFS_SIZE_LO && !swap)
		|=> wb_dat_o == size_val[31:0] ##1 !wb_ack_o;
	endproperty
	a_size_read: assert property (p_size_read) // RQ9
		else $error("Size read wrong.");

	property p_req_done;
		@(posedge ref_clk) disable iff (!rst_b)
		(wr_acc && wb_adr_i == `OFS_REQ) |=> s_r.req_done && wb_ack_o;
	endproperty
	a_req_done: assert property (p_req_done) // RQ1
		else $error("Request not completed.");

	// The acknowledge is a pulse, and a commit only ever rides on a good write request.
	property p_ack_one_cycle;
		@(posedge ref_clk) disable iff (!rst_b)
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_one_cycle: assert property (p_ack_one_cycle) // RQ1
		else $error("Acknowledge held too long.");

	property p_commit_ok;
		@(posedge ref_clk) disable iff (!rst_b)
		write_commit |-> wb_ack_o && s_r.req_status == blk_cfg_pkg::RS_OK && !s_r.ctrl.read_only;
	endproperty
	a_commit_ok: assert property (p_commit_ok) // RQ3
		else $error("Commit without a good write.");

	// Negotiation outcomes: a cleared status restarts, acceptance puts a mode in force.
	property p_status_clear;
		@(posedge ref_clk) disable iff (!rst_b)
		(wr_acc && wb_adr_i == `OFS_DEV_STATUS && wb_sel_i[0] && wb_dat_i[7:0] == 8'h0)
		|=> (cache_writeback == `RST_CACHE_MODE && s_r.drv_feat == 32'h0);
	endproperty
	a_status_clear: assert property (p_status_clear) // RQ13
		else $error("Status clear did not restart negotiation.");

	property p_accept_no_switch;
		@(posedge ref_clk) disable iff (!rst_b)
		(wr_acc && wb_adr_i == `OFS_DEV_STATUS && wb_sel_i[0] && !s_r.ctrl.legacy
		&& wb_dat_i[`ST_FEAT_ACCEPTED] && !s_r.dev_status[`ST_FEAT_ACCEPTED]
		&& !s_r.drv_feat[`FB_CACHE_SWITCH])
		|=> cache_writeback == $past(s_r.drv_feat[`FB_FLUSH]);
	endproperty
	a_accept_no_switch: assert property (p_accept_no_switch) // RQ13
		else $error("Mode does not follow flush acceptance.");

	property p_legacy_ready_mode;
		@(posedge ref_clk) disable iff (!rst_b)
		(wr_acc && wb_adr_i == `OFS_DEV_STATUS && wb_sel_i[0] && s_r.ctrl.legacy
		&& wb_dat_i[`ST_DRIVER_READY] && !s_r.dev_status[`ST_DRIVER_READY]
		&& !s_r.drv_feat[`FB_CACHE_SWITCH])
		|=> cache_writeback == $past(s_r.drv_feat[`FB_FLUSH]);
	endproperty
	a_legacy_ready_mode: assert property (p_legacy_ready_mode) // RQ20
		else $error("Legacy ready did not set the mode.");

	property p_cache_write_refused;
		@(posedge ref_clk) disable iff (!rst_b)
		(wr_acc && wb_adr_i == `OFS_CACHE_MODE && !s_r.ctrl.legacy
		&& !s_r.drv_feat[`FB_CACHE_SWITCH]) |=> $stable(cache_writeback);
	endproperty
	a_cache_write_refused: assert property (p_cache_write_refused) // RQ12
		else $error("Cache byte written without switching.");

	// Guest byte order of a field, and the code given to an unknown request type.
	property p_guest_order;
		@(posedge ref_clk) disable iff (!rst_b)
		(req_acc && !wb_we_i && wb_adr_i == `OFS_SEG_SIZE && swap)
		|=> wb_dat_o == {seg_size_val[7:0], seg_size_val[15:8], seg_size_val[23:16],
		seg_size_val[31:24]};
	endproperty
	a_guest_order: assert property (p_guest_order) // RQ23
		else $error("Field not in guest order.");

	property p_unknown_type;
		@(posedge ref_clk) disable iff (!rst_b)
		(wr_acc && wb_adr_i == `OFS_REQ && !(wb_dat_i[7:0] inside {`RQT_READ, `RQT_WRITE,
		`RQT_FLUSH, `RQT_DISCARD, `RQT_ZERO_FILL}))
		|=> s_r.req_status == blk_cfg_pkg::RS_UNSUPP;
	endproperty
	a_unknown_type: assert property (p_unknown_type) // RQ1
		else $error("Unknown request not refused.");

endmodule // blk_cfg

`default_nettype wire

// ---- blk_cfg_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "blk_cfg_map.svh"

module blk_cfg_bench;
	logic ref_clk;
	logic rst_b;
	logic wb_cyc, wb_stb, wb_we;
	logic [7:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_wdat, wb_dat_o, rdat;
	logic wb_ack_o, cache_writeback, write_commit, cmt;
	int bad_count;
	int cmp_count;
	localparam logic [63:0] SZ = `VAL_SIZE;
	localparam logic [7:0] MAP_A [14] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
		8'h1c, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38};
	localparam logic [31:0] MAP_V [14] = '{SZ[31:0], SZ[63:32], `VAL_SEG_SIZE, `VAL_SEG_COUNT,
		{`VAL_SECTORS, `VAL_HEADS, `VAL_CYLINDERS}, `VAL_BLOCK_BYTES,
		{`VAL_MIN_XFER, `VAL_ALIGN_BLOCK, `VAL_PHYS_LOG2}, `VAL_OPT_XFER, `VAL_DISC_SECT,
		`VAL_DISC_SEG, `VAL_DISC_ALIGN, `VAL_ZF_SECT, `VAL_ZF_SEG, {24'h0, `VAL_ZF_DEALLOC}};

	blk_cfg uut (.ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cache_writeback(cache_writeback),
		.write_commit(write_commit));

	// Free-running bus clock at 20 MHz.
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// Every comparison is counted; a mismatch is reported at once.
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One classic Wishbone cycle; the slave's latency is not assumed, only bounded.
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_wdat <= d;
		wb_sel <= 4'hf;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		chk("wb_ack_o", 32'h1, {31'h0, wb_ack_o});
		rdat = wb_dat_o;
		cmt = write_commit;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] exp, input string name);
		wb(1'b0, a, 32'h0);
		chk(name, exp, rdat);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d);
	endtask

	function automatic logic [31:0] feat(input logic ro, input logic sw, input logic leg);
		feat = 32'h0;
		feat[`FB_SEG_SIZE] = 1'b1;
		feat[`FB_SEG_COUNT] = 1'b1;
		feat[`FB_GEOMETRY] = 1'b1;
		feat[`FB_BLOCK_BYTES] = 1'b1;
		feat[`FB_FLUSH] = 1'b1;
		feat[`FB_TOPOLOGY] = 1'b1;
		feat[`FB_DISCARD] = 1'b1;
		feat[`FB_ZERO_FILL] = 1'b1;
		feat[`FB_READ_ONLY] = ro;
		feat[`FB_CACHE_SWITCH] = sw;
		feat[`FB_BARRIER] = leg;
	endfunction

	function automatic logic [31:0] bswap(input logic [31:0] x);
		bswap = {x[7:0], x[15:8], x[23:16], x[31:24]};
	endfunction

	// Field map except the cache byte, read-only writes and an unmapped address.
	task t_map();
		for (int i = 0; i < 14; i++) begin
			rd(MAP_A[i], MAP_V[i], "config field");
		end
		wr(`OFS_SEG_SIZE, 32'hffff_ffff);
		rd(`OFS_SEG_SIZE, `VAL_SEG_SIZE, "read-only field after write");
		rd(`OFS_ZF_DEALLOC, {24'h0, `VAL_ZF_DEALLOC}, "second pad area");
		wr(8'h60, 32'h1234_5678);
		rd(8'h60, 32'h0, "unmapped address");
	endtask

	// Offered features follow the backend control settings.
	task t_features();
		rd(`OFS_DEV_FEAT, feat(1'b0, 1'b0, 1'b0), "reset features");
		wr(`OFS_CTRL, 32'h18);
		rd(`OFS_DEV_FEAT, feat(1'b0, 1'b1, 1'b0), "switch features");
		wr(`OFS_CTRL, 32'h19);
		rd(`OFS_DEV_FEAT, feat(1'b0, 1'b1, 1'b1), "legacy features");
		wr(`OFS_CTRL, 32'h1c);
		rd(`OFS_DEV_FEAT, feat(1'b1, 1'b1, 1'b0), "read-only features");
	endtask

	// Negotiate with accepted features fa, then check the resulting cache byte.
	task nego(input logic [31:0] fa, input logic [7:0] st, input logic m, input string name);
		wr(`OFS_DEV_STATUS, 32'h0);
		wr(`OFS_DRV_FEAT, fa);
		wr(`OFS_DEV_STATUS, {24'h0, st});
		rd(`OFS_CACHE_MODE, {31'h0, m}, name);
		chk("cache_writeback", {31'h0, m}, {31'h0, cache_writeback});
	endtask

	// Cache mode in force after negotiation, and its write access.
	task t_cache();
		wr(`OFS_CTRL, 32'h18);
		nego(32'h0800, 8'h0a, 1'b0, "switch without flush");
		wr(`OFS_CACHE_MODE, 32'h1);
		rd(`OFS_CACHE_MODE, 32'h1, "cache byte written 1");
		chk("cache_writeback", 32'h1, {31'h0, cache_writeback});
		nego(32'h0a00, 8'h0a, 1'b1, "switch and flush");
		wr(`OFS_CACHE_MODE, 32'h0);
		rd(`OFS_CACHE_MODE, 32'h0, "cache byte written 0");
		nego(32'h0200, 8'h0a, 1'b1, "flush only");
		wr(`OFS_CACHE_MODE, 32'h0);
		rd(`OFS_CACHE_MODE, 32'h1, "cache byte without switch");
		nego(32'h0, 8'h0a, 1'b0, "no cache features");
	endtask

	// Legacy interface: status and feature writes versus the cache mode, byte order.
	task t_legacy();
		wr(`OFS_CTRL, 32'h19);
		nego(32'h0800, 8'h02, 1'b1, "legacy feature and driver writes");
		wr(`OFS_DEV_STATUS, 32'h06);
		rd(`OFS_CACHE_MODE, 32'h1, "legacy ready with switch");
		wr(`OFS_DEV_STATUS, 32'h0);
		wr(`OFS_CACHE_MODE, 32'h0);
		rd(`OFS_CACHE_MODE, 32'h0, "legacy early cache write");
		nego(32'h0200, 8'h06, 1'b1, "legacy ready without switch");
		nego(32'h0, 8'h06, 1'b0, "legacy ready with nothing accepted");
		wr(`OFS_CTRL, 32'h0b);
		rd(`OFS_SEG_SIZE, bswap(`VAL_SEG_SIZE), "guest order field");
		rd(`OFS_SIZE_HI, bswap(SZ[31:0]), "guest order size");
		wr(`OFS_CTRL, 32'h0a);
		rd(`OFS_SEG_SIZE, `VAL_SEG_SIZE, "little-endian field");
	endtask

	// Every request type, writable and read-only, back to back.
	task t_requests();
		logic [7:0] ty [6] = '{`RQT_READ, `RQT_WRITE, `RQT_FLUSH, `RQT_DISCARD,
			`RQT_ZERO_FILL, 8'h07};
		logic [1:0] code;
		for (int ro = 0; ro < 2; ro++) begin
			wr(`OFS_CTRL, ro ? 32'h0c : 32'h08);
			for (int i = 0; i < 6; i++) begin
				code = (i == 5) ? 2'd2 : (ro == 1 && i != 0 && i != 2) ? 2'd1 : 2'd0;
				wr(`OFS_REQ, {24'h0, ty[i]});
				chk("write_commit", {31'h0, ro == 0 && i == 1}, {31'h0, cmt});
				rd(`OFS_REQ_STATUS, 32'h100 | code, "request status");
			end
		end
	endtask

	// Single place where the run ends.
	task test_done();
		$display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Generous bound: the whole sequence needs well under a thousand cycles.
	initial begin
		repeat (5000) @(posedge ref_clk);
		bad_count++;
		$display("CHECK FAILED watchdog expected done seen hang");
		test_done();
	end

	// Reset for 8 cycles, then the scenarios in order.
	initial begin
		rst_b = 1'b0;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 8'h00;
		wb_sel = 4'h0;
		wb_wdat = 32'h0;
		bad_count = 0;
		cmp_count = 0;
		repeat (8) @(posedge ref_clk);
		chk("reset ack", 32'h0, {31'h0, wb_ack_o});
		chk("reset cache mode", 32'h1, {31'h0, cache_writeback});
		rst_b <= 1'b1;
		t_map();
		t_features();
		t_cache();
		t_legacy();
		t_requests();
		test_done();
	end
endmodule // blk_cfg_bench

`default_nettype wire
